// *** inc/switch_control_pkg.sv ***
// constants for the switch control register block
package switch_control_pkg;
    localparam logic [11:0] SWITCH_CONTROL_OFFSET = 12'h404;
    localparam int BIT_FULL_RESET = 0;
    localparam int BIT_WARM_RESET = 1;
    localparam int BIT_HOLD = 2;
    localparam int BIT_UNLOCK = 3;
    localparam int BIT_BUDGET_UNLOCK = 4;
    localparam int BIT_LINK_DOWN_DIS = 5;
    localparam int BIT_EEPROM_SKIP = 6;
    localparam int BIT_STRICT_ORDER = 7;
    localparam int BIT_PEER_DIS = 8;
    localparam int BIT_STORE_FWD = 14;
    localparam int BIT_LOCK_BYPASS = 15;
    localparam logic [31:0] SWITCH_CONTROL_WRITE_MASK = 32'h0000_C1FC;
    localparam logic [31:0] BUDGET_RESET = 32'h0000_0000;
    localparam int BUDGET_COUNT = 8;
    localparam logic [2:0] BUDGET_IDX_W = 3'h7;
endpackage : switch_control_pkg

// *** rtl/switch_control_budget_regs.sv ***
// bank of eight power-budget value registers guarded by the unlock bit
`timescale 1ns/1ps
module switch_control_budget_regs
    import switch_control_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic unlock,
    input wire logic wr_en,
    input wire logic [2:0] wr_index,
    input wire logic [31:0] wr_data,
    input wire logic [2:0] rd_index,
    output logic [31:0] rd_data
);
    logic [31:0] value [BUDGET_COUNT];

    genvar g;
    generate
        for (g = 0; g < BUDGET_COUNT; g++)
        begin : g_entry
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    value[g] <= BUDGET_RESET;
                else if (clk_en && wr_en && unlock && wr_index == 3'(g))
                    value[g] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= BUDGET_RESET;
        else if (clk_en)
            rd_data <= value[rd_index];
    end

    blocked_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && wr_en && !unlock |=> $stable(value[$past(wr_index)]))
        else $error("budget register changed while locked");
endmodule // switch_control_budget_regs

// *** rtl/switch_control_switch_control.sv ***
// switch control register with reset triggers, hold and policy outputs
// Overview of operation
// - writing one starts fundamental reset; reads zero
// - writing one starts hot reset; reads zero
// - hold bit keeps switch logic in reset
// - hold frozen after reset; set on EEPROM error
// - hold initial value is captured strap
// - unlock bit gates writes to lockable fields
// - unlock forced one during reset operation
// - budget unlock makes budget values writable
// - locked budget writes are ignored
// - bit 5 blocks link-down hot reset
// - bit 7 forces strict ordering
// - bit 8 disables peer traffic
// - bit 14 forces store and forward
// - bit 15 bypasses lock semantics
`timescale 1ns/1ps
module switch_control_switch_control
    import switch_control_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic budget_wr,
    input wire logic [2:0] budget_index,
    output logic [31:0] budget_rdata,
    input wire logic hold_strap,
    input wire logic reset_in_progress,
    input wire logic eeprom_error,
    input wire logic link_down_event,
    output logic full_reset_trigger,
    output logic warm_reset_trigger,
    output logic hold_in_reset,
    output logic warm_reset_eeprom_skip,
    output logic strict_ordering_force,
    output logic peer_traffic_disable,
    output logic store_forward_force,
    output logic lock_semantics_bypass
);
    import switch_control_pkg::*;

    logic rst_meta;
    logic rst_sync_n;
    logic strap_taken;
    logic write_unlock_enable;
    logic budget_value_unlock;
    logic link_down_reset_disable;
    logic hit_wr;
    logic hit_rd;
    logic unlock_eff;
    logic [31:0] next_rdata;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign hit_wr = reg_wr && reg_addr == SWITCH_CONTROL_OFFSET;
    assign hit_rd = reg_rd && reg_addr == SWITCH_CONTROL_OFFSET;
    assign unlock_eff = write_unlock_enable || reset_in_progress;

    // triggers are one-cycle pulses; a zero write is ignored
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            full_reset_trigger <= 1'b0;
            warm_reset_trigger <= 1'b0;
        end
        else if (clk_en)
        begin
            full_reset_trigger <= hit_wr && reg_wdata[BIT_FULL_RESET];
            warm_reset_trigger <= (hit_wr && reg_wdata[BIT_WARM_RESET])
                || (link_down_event && !link_down_reset_disable);
        end
    end

    // the strap is sampled by a clocked process on the first enabled cycle after reset release, never under async reset
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            hold_in_reset <= 1'b0;
            strap_taken <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!strap_taken)
            begin
                hold_in_reset <= hold_strap;
                strap_taken <= 1'b1;
            end
            else if (eeprom_error && reset_in_progress)
                hold_in_reset <= 1'b1;
            else if (hit_wr && reset_in_progress)
                hold_in_reset <= reg_wdata[BIT_HOLD];
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            write_unlock_enable <= 1'b0;
            budget_value_unlock <= 1'b0;
        end
        else if (clk_en)
        begin
            if (reset_in_progress)
                write_unlock_enable <= 1'b1;
            else if (hit_wr)
                write_unlock_enable <= reg_wdata[BIT_UNLOCK];
            if (hit_wr && unlock_eff)
                budget_value_unlock <= reg_wdata[BIT_BUDGET_UNLOCK];
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            link_down_reset_disable <= 1'b0;
            warm_reset_eeprom_skip <= 1'b0;
            strict_ordering_force <= 1'b0;
            peer_traffic_disable <= 1'b0;
            store_forward_force <= 1'b0;
            lock_semantics_bypass <= 1'b0;
        end
        else if (clk_en && hit_wr)
        begin
            link_down_reset_disable <= reg_wdata[BIT_LINK_DOWN_DIS];
            warm_reset_eeprom_skip <= reg_wdata[BIT_EEPROM_SKIP];
            strict_ordering_force <= reg_wdata[BIT_STRICT_ORDER];
            peer_traffic_disable <= reg_wdata[BIT_PEER_DIS];
            store_forward_force <= reg_wdata[BIT_STORE_FWD];
            lock_semantics_bypass <= reg_wdata[BIT_LOCK_BYPASS];
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rdata[BIT_HOLD] = hold_in_reset;
        next_rdata[BIT_UNLOCK] = write_unlock_enable;
        next_rdata[BIT_BUDGET_UNLOCK] = budget_value_unlock;
        next_rdata[BIT_LINK_DOWN_DIS] = link_down_reset_disable;
        next_rdata[BIT_EEPROM_SKIP] = warm_reset_eeprom_skip;
        next_rdata[BIT_STRICT_ORDER] = strict_ordering_force;
        next_rdata[BIT_PEER_DIS] = peer_traffic_disable;
        next_rdata[BIT_STORE_FWD] = store_forward_force;
        next_rdata[BIT_LOCK_BYPASS] = lock_semantics_bypass;
        next_rdata = next_rdata & SWITCH_CONTROL_WRITE_MASK;
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en && hit_rd)
            reg_rdata <= next_rdata;
    end

    switch_control_budget_regs u_budget (
        .clock(clock),
        .rst_n(rst_sync_n),
        .clk_en(clk_en),
        .unlock(budget_value_unlock),
        .wr_en(budget_wr),
        .wr_index(budget_index),
        .wr_data(reg_wdata),
        .rd_index(budget_index),
        .rd_data(budget_rdata)
    );

    trigger_pulse_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && hit_wr && reg_wdata[0] |=> full_reset_trigger
        ##1 (!full_reset_trigger || !$past(clk_en) || $past(hit_wr && reg_wdata[0])))
        else $error("full reset trigger wrong");
    warm_trigger_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && hit_wr && reg_wdata[1] |=> warm_reset_trigger)
        else $error("warm reset trigger missing");
    hold_frozen_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        strap_taken && $past(strap_taken) && !reset_in_progress && !$past(reset_in_progress)
        |-> $stable(hold_in_reset))
        else $error("hold changed outside reset");
    unlock_forced_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && reset_in_progress |=> write_unlock_enable)
        else $error("unlock not forced during reset");
    locked_field_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !unlock_eff |=> $stable(budget_value_unlock))
        else $error("lockable field changed while locked");
    link_down_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && link_down_event && link_down_reset_disable && !hit_wr |=> !warm_reset_trigger)
        else $error("link down reset not suppressed");
    read_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (reg_rdata & ~SWITCH_CONTROL_WRITE_MASK) == 32'h0000_0000)
        else $error("reserved or trigger bits read nonzero");
    policy_store_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clk_en && hit_wr |=> strict_ordering_force == $past(reg_wdata[7]) && store_forward_force == $past(reg_wdata[14]))
        else $error("policy bits not stored");
endmodule // switch_control_switch_control

// *** tb/switch_control_switch_control_tb.sv ***
// self-checking bench for the switch control register block
`timescale 1ns/1ps
module switch_control_switch_control_tb;
    import switch_control_pkg::*;
    logic clock = 0;
    logic rst_n = 0;
    logic clk_en = 1;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic budget_wr = 0;
    logic hold_strap = 1;
    logic reset_in_progress = 0;
    logic eeprom_error = 0;
    logic link_down_event = 0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [2:0] budget_index = 3'h0;
    logic [31:0] reg_rdata, budget_rdata, v;
    logic full_reset_trigger, warm_reset_trigger, hold_in_reset, warm_reset_eeprom_skip, ft, wt;
    logic strict_ordering_force, peer_traffic_disable, store_forward_force, lock_semantics_bypass;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 clock = ~clock;

    switch_control_switch_control i_switch_control_switch_control (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .budget_wr(budget_wr), .budget_index(budget_index), .budget_rdata(budget_rdata),
        .hold_strap(hold_strap), .reset_in_progress(reset_in_progress), .eeprom_error(eeprom_error),
        .link_down_event(link_down_event), .full_reset_trigger(full_reset_trigger),
        .warm_reset_trigger(warm_reset_trigger), .hold_in_reset(hold_in_reset),
        .warm_reset_eeprom_skip(warm_reset_eeprom_skip), .strict_ordering_force(strict_ordering_force),
        .peer_traffic_disable(peer_traffic_disable), .store_forward_force(store_forward_force),
        .lock_semantics_bypass(lock_semantics_bypass));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under 400 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge clock);
        #10;
    endtask

    // trigger pulses are caught in the cycle after the taken edge
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 0;
        ft = full_reset_trigger;
        wt = warm_reset_trigger;
        step(1);
    endtask

    task automatic rd(logic [11:0] a);
        reg_rd = 1;
        reg_addr = a;
        step(1);
        reg_rd = 0;
        step(1);
        v = reg_rdata;
    endtask

    task automatic bwr(logic [2:0] i, logic [31:0] d);
        budget_wr = 1;
        budget_index = i;
        reg_wdata = d;
        step(1);
        budget_wr = 0;
        step(1);
    endtask

    task automatic bchk(logic [2:0] i, logic [31:0] e);
        budget_index = i;
        step(2);
        check("budget value", budget_rdata, e);
    endtask

    function automatic logic [31:0] pol();
        return {27'h0, warm_reset_eeprom_skip, strict_ordering_force, peer_traffic_disable,
            store_forward_force, lock_semantics_bypass};
    endfunction

    initial
    begin
        step(5);
        rst_n = 1;
        step(4);
        check("hold pin", 32'(hold_in_reset), 32'h1);
        rd(SWITCH_CONTROL_OFFSET);
        check("reset value", v, 32'h0000_0004);
        $display("test reset done");
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0008);
        wr(SWITCH_CONTROL_OFFSET, 32'hFFFF_FFFF);
        check("full pulse", 32'(ft), 32'h1);
        check("warm pulse", 32'(wt), 32'h1);
        check("pulse end", 32'(full_reset_trigger | warm_reset_trigger), 32'h0);
        check("policy on", pol(), 32'h0000_001F);
        rd(SWITCH_CONTROL_OFFSET);
        check("all ones", v, 32'h0000_C1FC);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0008);
        rd(SWITCH_CONTROL_OFFSET);
        check("budget lock off", v, 32'h0000_000C);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0000);
        check("zero write pulses", 32'({ft, wt}), 32'h0);
        check("policy off", pol(), 32'h0);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0010);
        rd(SWITCH_CONTROL_OFFSET);
        check("locked write", v, 32'h0000_0004);
        $display("test fields done");
        bwr(3'h5, 32'hA5A5_0F0F);
        bchk(3'h5, 32'h0);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0008);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0018);
        bwr(3'h0, 32'h1234_5678);
        bwr(3'h7, 32'hFFFF_0001);
        bchk(3'h0, 32'h1234_5678);
        bchk(3'h7, 32'hFFFF_0001);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0008);
        bwr(3'h7, 32'h0000_0000);
        bchk(3'h7, 32'hFFFF_0001);
        $display("test budget done");
        link_down_event = 1;
        step(1);
        link_down_event = 0;
        check("link down reset", 32'(warm_reset_trigger), 32'h1);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0020);
        link_down_event = 1;
        step(1);
        link_down_event = 0;
        check("link down masked", 32'(warm_reset_trigger), 32'h0);
        step(1);
        check("link down masked", 32'(warm_reset_trigger), 32'h0);
        $display("test link down done");
        reset_in_progress = 1;
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0000);
        check("hold cleared", 32'(hold_in_reset), 32'h0);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0010);
        eeprom_error = 1;
        step(1);
        eeprom_error = 0;
        step(1);
        check("eeprom error hold", 32'(hold_in_reset), 32'h1);
        reset_in_progress = 0;
        rd(SWITCH_CONTROL_OFFSET);
        check("forced unlock", v, 32'h0000_001C);
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_0010);
        check("hold frozen", 32'(hold_in_reset), 32'h1);
        $display("test reset operation done");
        wr(12'h408, 32'hFFFF_FFFF);
        clk_en = 0;
        wr(SWITCH_CONTROL_OFFSET, 32'h0000_C1F8);
        clk_en = 1;
        rd(SWITCH_CONTROL_OFFSET);
        check("decode and enable", v, 32'h0000_0014);
        $display("test decode done");
        hold_strap = 0;
        rst_n = 0;
        step(2);
        rst_n = 1;
        step(4);
        check("hold pin low", 32'(hold_in_reset), 32'h0);
        rd(SWITCH_CONTROL_OFFSET);
        check("second reset value", v, 32'h0000_0000);
        check("policy after reset", pol(), 32'h0);
        $display("test second reset done");
        final_report();
    end
endmodule // switch_control_switch_control_tb
